// ==== hw/lpdm_autocfg.sv ====
// serial nonvolatile image loader run once after reset
`timescale 1ns/100ps
`default_nettype none
`include "lpdm_defines.svh"
module lpdm_autocfg
    import lpdm_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    ee_data,
    output logic                         ee_clk,
    output logic                         ee_cs_n,
    output logic                         done,
    output logic [`LPDM_IMG_BITS-1:0]    image
);
    typedef struct packed {
        lpdm_ac_st_type             st;
        logic [9:0]                 div;
        logic [6:0]                 cnt;
        logic [`LPDM_IMG_BITS-1:0]  img;
        logic                       ee_clk;
        logic                       ee_cs_n;
        logic                       done;
        logic                       s1;
        logic                       s2;
        logic                       s3;
        logic                       filt;
    } lpdm_ac_type;

    lpdm_ac_type s_r;
    lpdm_ac_type s_nxt;

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.s1   = ee_data;
        s_nxt.s2   = s_r.s1;
        s_nxt.s3   = s_r.s2;
        // glitch guard: only a value held by two stages counts
        if (s_r.s2 == s_r.s3)
        begin
            s_nxt.filt = s_r.s3;
        end
        case (s_r.st)
            AC_START:
            begin
                s_nxt.ee_cs_n = 1'b0;
                s_nxt.st      = AC_RUN;
            end
            AC_RUN:
            begin
                s_nxt.div = s_r.div + 10'h001;
                if (s_r.div == 10'(`LPDM_AC_HALF_CYC - 1))
                begin
                    s_nxt.div    = 10'h000;
                    s_nxt.ee_clk = ~s_r.ee_clk;
                    if (!s_r.ee_clk)
                    begin
                        s_nxt.img = {s_r.img[`LPDM_IMG_BITS-2:0], s_r.filt}; // RQ7
                        s_nxt.cnt = s_r.cnt + 7'h01;
                        if (s_r.cnt == 7'(`LPDM_IMG_BITS - 1))
                        begin
                            s_nxt.st      = AC_DONE;
                            s_nxt.ee_cs_n = 1'b1;
                            s_nxt.ee_clk  = 1'b0;
                            s_nxt.done    = 1'b1;
                        end
                    end
                end
            end
            AC_DONE:
            begin
                s_nxt.done = 1'b1;
            end
            default:
            begin
                s_nxt.st = AC_START;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r         <= '0;
            s_r.st      <= AC_START;
            s_r.ee_cs_n <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ee_clk  = s_r.ee_clk;
    assign ee_cs_n = s_r.ee_cs_n;
    assign done    = s_r.done;
    assign image   = s_r.img;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_image_bit_count: assert property ($rose(s_r.done) |-> s_r.cnt == 7'(`LPDM_IMG_BITS)) // RQ7
        else $error("image load ended at wrong bit count");
    a_image_cs_released: assert property (s_r.done |-> s_r.ee_cs_n && !s_r.ee_clk) // RQ7
        else $error("serial memory still selected after load");

endmodule
`default_nettype wire

// ==== hw/lpdm_bridge.sv ====
// local bus to pci direct master bridge with host bring-up
// Function
// [RQ1] Each cycle type drives its fixed pci command nibble (cfg A/B, io 2/3, mem 6/7, special 1, intack 0).
// [RQ2] The local processor loads base address and command type before using the window.
// [RQ3] The pci address is the window offset added to the programmed base address.
// [RQ4] The command type of every master cycle comes from the programmed command field.
// [RQ5] A window read makes a pci read and a window write makes a pci write.
// [RQ6] No pci cycle is mastered while the mastering permission is clear, which it is after reset.
// [RQ7] After reset the serial image is loaded and sets permission and identity and class fields.
// [RQ8] The image loads the local bus configuration that selects the local protocol.
// [RQ9] The image loads the host reset control, driven out as a true and a complementary pin.
// [RQ10] After loading, host reset is released or held as the image says.
// [RQ11] A held host is released by an external pci master writing the host reset control; the code ignores such writes until the image has loaded.
// [RQ12] With permission clear no configuration cycle reaches any device, so the host must set it first.
// [RQ13] The host configures pci devices through the window, usually this bridge first.
// [RQ14] Software on both buses arbitrates shared memory so one word is never read and written at once.
// [RQ15] The local access waits until the pci cycle completes, then gets read data or an acknowledge.
`timescale 1ns/100ps
`default_nettype none
`include "lpdm_defines.svh"
module lpdm_bridge
    import lpdm_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    input  wire logic           ctl_wr,
    input  wire logic [31:0]    ctl_base,
    input  wire logic [2:0]     ctl_ctype,
    input  wire logic           lb_req,
    input  wire logic           lb_wr,
    input  wire logic [15:0]    lb_offset,
    input  wire logic [31:0]    lb_wdata,
    output logic                lb_ack,
    output logic                lb_refused,
    output logic [31:0]         lb_rdata,
    output logic                pci_req,
    output logic [3:0]          pci_cmd,
    output logic [31:0]         pci_addr,
    output logic [31:0]         pci_wdata,
    input  wire logic           pci_done,
    input  wire logic [31:0]    pci_rdata,
    input  wire logic           ext_cfg_wr,
    input  wire logic           ext_master_en,
    input  wire logic           ext_host_hold,
    input  wire logic           ee_data,
    output logic                ee_clk,
    output logic                ee_cs_n,
    output logic                cfg_loaded,
    output logic                master_en,
    output logic [15:0]         vendor_id,
    output logic [15:0]         device_id,
    output logic [23:0]         class_code,
    output logic [20:0]         lbus_cfg,
    output logic                host_reset_out,
    output logic                host_reset_out_n
);
    // ------------------------------------------------------------
    // command encoding
    // ------------------------------------------------------------
    function automatic logic [3:0] cmd_code(input lpdm_ctype_type t, input logic wr);
        logic [3:0] c;
        c = `LPDM_CMD_MEM_RD;
        case (t)
            CT_CFG:     c = wr ? `LPDM_CMD_CFG_WR : `LPDM_CMD_CFG_RD;
            CT_IO:      c = wr ? `LPDM_CMD_IO_WR : `LPDM_CMD_IO_RD;
            CT_MEM:     c = wr ? `LPDM_CMD_MEM_WR : `LPDM_CMD_MEM_RD;
            CT_SPECIAL: c = `LPDM_CMD_SPECIAL;
            CT_INTACK:  c = `LPDM_CMD_INTACK;
            default:    c = wr ? `LPDM_CMD_MEM_WR : `LPDM_CMD_MEM_RD;
        endcase
        return c;
    endfunction

    typedef struct packed {
        lpdm_br_st_type   st;
        logic [31:0]      base;
        lpdm_ctype_type   ctype;
        logic             is_wr;
        logic             lb_ack;
        logic             lb_refused;
        logic [31:0]      lb_rdata;
        logic             pci_req;
        logic [3:0]       pci_cmd;
        logic [31:0]      pci_addr;
        logic [31:0]      pci_wdata;
        logic             loaded;
        logic             master_en;
        logic [15:0]      vid;
        logic [15:0]      did;
        logic [23:0]      cls;
        logic [20:0]      lbus;
        logic             hrst;
        logic             hrst_n;
    } lpdm_br_type;

    lpdm_br_type                 s_r;
    lpdm_br_type                 s_nxt;
    logic                        ac_done;
    logic [`LPDM_IMG_BITS-1:0]   ac_image;

    lpdm_autocfg u_autocfg (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ee_data (ee_data),
        .ee_clk  (ee_clk),
        .ee_cs_n (ee_cs_n),
        .done    (ac_done),
        .image   (ac_image)
    );

    always_comb
    begin
        s_nxt            = s_r;
        s_nxt.lb_ack     = 1'b0;
        s_nxt.lb_refused = 1'b0;
        // ------------------------------------------------------------
        // bring-up from the serial image
        // ------------------------------------------------------------
        if (ac_done && !s_r.loaded)
        begin
            s_nxt.loaded    = 1'b1;
            s_nxt.master_en = ac_image[`LPDM_IMG_MEN_BIT]; // RQ7
            s_nxt.vid       = ac_image[`LPDM_IMG_VID_HI:`LPDM_IMG_VID_LO];
            s_nxt.did       = ac_image[`LPDM_IMG_DID_HI:`LPDM_IMG_DID_LO];
            s_nxt.cls       = ac_image[`LPDM_IMG_CLS_HI:`LPDM_IMG_CLS_LO];
            s_nxt.lbus      = ac_image[`LPDM_IMG_LBUS_HI:`LPDM_IMG_LBUS_LO]; // RQ8
            s_nxt.hrst      = ac_image[`LPDM_IMG_HOLD_BIT]; // RQ10
        end
        else if (ext_cfg_wr && s_r.loaded)
        begin
            // external master may hand over permission and free the host
            s_nxt.master_en = ext_master_en;
            s_nxt.hrst      = ext_host_hold; // RQ11
        end
        s_nxt.hrst_n = ~s_nxt.hrst; // RQ9
        // ------------------------------------------------------------
        // window control register
        // ------------------------------------------------------------
        if (ctl_wr)
        begin
            s_nxt.base  = ctl_base;
            s_nxt.ctype = lpdm_ctype_type'(ctl_ctype); // RQ4
        end
        // ------------------------------------------------------------
        // pass-through cycle
        // ------------------------------------------------------------
        case (s_r.st)
            BR_IDLE:
            begin
                if (lb_req)
                begin
                    if (s_r.master_en && s_r.loaded) // RQ6
                    begin
                        s_nxt.is_wr     = lb_wr; // RQ5
                        s_nxt.pci_cmd   = cmd_code(s_r.ctype, lb_wr); // RQ1
                        s_nxt.pci_addr  = s_r.base + {16'h0000, lb_offset}; // RQ3
                        s_nxt.pci_wdata = lb_wdata;
                        s_nxt.pci_req   = 1'b1;
                        s_nxt.st        = BR_BUSY;
                    end
                    else
                    begin
                        // answered at once so a missing permission never hangs the cpu
                        s_nxt.lb_ack     = 1'b1; // RQ12
                        s_nxt.lb_refused = 1'b1;
                        s_nxt.lb_rdata   = `LPDM_RD_REFUSED;
                    end
                end
            end
            BR_BUSY:
            begin
                if (pci_done)
                begin
                    s_nxt.pci_req  = 1'b0;
                    s_nxt.lb_ack   = 1'b1; // RQ15
                    s_nxt.lb_rdata = s_r.is_wr ? 32'h00000000 : pci_rdata;
                    s_nxt.st       = BR_IDLE;
                end
            end
            default:
            begin
                s_nxt.st      = BR_IDLE;
                s_nxt.pci_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r           <= '0;
            s_r.st        <= BR_IDLE;
            s_r.ctype     <= CT_MEM;
            s_r.master_en <= `LPDM_RST_MASTER_EN; // RQ6
            s_r.hrst      <= `LPDM_RST_HOST_RST;
            s_r.hrst_n    <= ~`LPDM_RST_HOST_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign lb_ack           = s_r.lb_ack;
    assign lb_refused       = s_r.lb_refused;
    assign lb_rdata         = s_r.lb_rdata;
    assign pci_req          = s_r.pci_req;
    assign pci_cmd          = s_r.pci_cmd;
    assign pci_addr         = s_r.pci_addr;
    assign pci_wdata        = s_r.pci_wdata;
    assign cfg_loaded       = s_r.loaded;
    assign master_en        = s_r.master_en;
    assign vendor_id        = s_r.vid;
    assign device_id        = s_r.did;
    assign class_code       = s_r.cls;
    assign lbus_cfg         = s_r.lbus;
    assign host_reset_out   = s_r.hrst;
    assign host_reset_out_n = s_r.hrst_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence issue_s;
        s_r.st == BR_IDLE && lb_req && s_r.master_en && s_r.loaded;
    endsequence
    sequence finish_s;
        s_r.st == BR_BUSY && pci_done;
    endsequence

    a_cmd_cfg_read: assert property (issue_s and (s_r.ctype == CT_CFG && !lb_wr) |=> s_r.pci_cmd == 4'hA) // RQ1
        else $error("config read nibble wrong");
    a_cmd_mem_write: assert property (issue_s and (s_r.ctype == CT_MEM && lb_wr) |=> s_r.pci_cmd == 4'h7) // RQ1
        else $error("memory write nibble wrong");
    a_addr_sum: assert property (issue_s |=> s_r.pci_addr == $past(s_r.base) + {16'h0000, $past(lb_offset)}) // RQ3
        else $error("pci address is not base plus offset");
    a_dir_follow: assert property (issue_s |=> s_r.pci_req && s_r.is_wr == $past(lb_wr)) // RQ5
        else $error("pci direction differs from local access");
    a_no_master_off: assert property ($rose(s_r.pci_req) |-> $past(s_r.master_en)) // RQ6
        else $error("pci cycle started without permission");
    a_refuse_off: assert property (s_r.st == BR_IDLE && lb_req && !s_r.master_en |=> s_r.lb_ack && s_r.lb_refused && !s_r.pci_req) // RQ12
        else $error("access without permission not refused");
    a_wait_done: assert property (finish_s |=> s_r.lb_ack && !s_r.pci_req ##1 !s_r.lb_ack) // RQ15
        else $error("local ack not one cycle after pci done");
    a_rdata_pass: assert property (finish_s and !s_r.is_wr |=> s_r.lb_rdata == $past(pci_rdata)) // RQ15
        else $error("read data not returned");
    a_host_pair: assert property (s_r.hrst != s_r.hrst_n) // RQ9
        else $error("host reset pins not complementary");
    a_host_held_load: assert property (!s_r.loaded |-> s_r.hrst) // RQ10
        else $error("host released before image loaded");
    a_lbus_load: assert property (ac_done && !s_r.loaded |=> s_r.lbus == $past(ac_image[21:1])) // RQ8
        else $error("local bus config not loaded from image");

endmodule
`default_nettype wire

// ==== hw/lpdm_defines.svh ====
// constants for the local-to-pci direct master bridge
`ifndef LPDM_DEFINES_SVH
`define LPDM_DEFINES_SVH

// pci command nibbles
`define LPDM_CMD_INTACK    4'h0
`define LPDM_CMD_SPECIAL   4'h1
`define LPDM_CMD_IO_RD     4'h2
`define LPDM_CMD_IO_WR     4'h3
`define LPDM_CMD_MEM_RD    4'h6
`define LPDM_CMD_MEM_WR    4'h7
`define LPDM_CMD_CFG_RD    4'hA
`define LPDM_CMD_CFG_WR    4'hB

// serial image timing
`define LPDM_CLK_PERIOD_NS 10
`define LPDM_AC_HALF_NS    5000
`define LPDM_AC_HALF_CYC   ((`LPDM_AC_HALF_NS + `LPDM_CLK_PERIOD_NS - 1) / `LPDM_CLK_PERIOD_NS)

// serial image layout, first bit shifted in lands at the top
`define LPDM_IMG_BITS      79
`define LPDM_IMG_MEN_BIT   78
`define LPDM_IMG_VID_HI    77
`define LPDM_IMG_VID_LO    62
`define LPDM_IMG_DID_HI    61
`define LPDM_IMG_DID_LO    46
`define LPDM_IMG_CLS_HI    45
`define LPDM_IMG_CLS_LO    22
`define LPDM_IMG_LBUS_HI   21
`define LPDM_IMG_LBUS_LO   1
`define LPDM_IMG_HOLD_BIT  0

// reset values and refused read data
`define LPDM_RST_MASTER_EN 1'h0
`define LPDM_RST_HOST_RST  1'h1
`define LPDM_RD_REFUSED    32'hFFFFFFFF

`endif

// ==== hw/lpdm_pkg.sv ====
// types for the local-to-pci direct master bridge
`default_nettype none
`include "lpdm_defines.svh"
package lpdm_pkg;
    typedef enum logic [2:0] {CT_CFG, CT_IO, CT_MEM, CT_SPECIAL, CT_INTACK} lpdm_ctype_type;
    typedef enum logic [1:0] {AC_START, AC_RUN, AC_DONE} lpdm_ac_st_type;
    typedef enum logic [0:0] {BR_IDLE, BR_BUSY} lpdm_br_st_type;
endpackage
`default_nettype wire

// ==== verif/lpdm_bridge_bench.sv ====
// self-checking bench for the local-to-pci direct master bridge
`timescale 1ns/100ps
`default_nettype none
`include "lpdm_defines.svh"
module lpdm_bridge_bench;
    import lpdm_pkg::*;
    // identity values are arbitrary
    localparam logic [15:0] VEND = 16'h1D5A;
    localparam logic [15:0] DEV  = 16'h0B17;
    localparam logic [23:0] CLS  = 24'h0B4E21;
    localparam logic [20:0] LBUS = 21'h0A5C3;
    localparam logic [78:0] IMG  = {1'b1, VEND, DEV, CLS, LBUS, 1'b0};
    logic        sys_clk, rst_n, ctl_wr, lb_req, lb_wr, lb_ack, lb_refused;
    logic        pci_req, pci_done, ext_cfg_wr, ext_master_en, ext_host_hold;
    logic        ee_data, ee_clk, ee_cs_n, cfg_loaded, master_en;
    logic        host_reset_out, host_reset_out_n;
    logic [2:0]  ctl_ctype;
    logic [3:0]  pci_cmd, lat;
    logic [15:0] lb_offset, vendor_id, device_id;
    logic [20:0] lbus_cfg;
    logic [23:0] class_code;
    logic [31:0] ctl_base, lb_wdata, lb_rdata, pci_addr, pci_wdata, pci_rdata, base;
    int          fails, checked, i, n;
    logic [3:0]  rd_cmd [5] = '{`LPDM_CMD_CFG_RD, `LPDM_CMD_IO_RD, `LPDM_CMD_MEM_RD,
                                `LPDM_CMD_SPECIAL, `LPDM_CMD_INTACK};
    logic [3:0]  wr_cmd [5] = '{`LPDM_CMD_CFG_WR, `LPDM_CMD_IO_WR, `LPDM_CMD_MEM_WR,
                                `LPDM_CMD_SPECIAL, `LPDM_CMD_INTACK};

    lpdm_bridge uut (.sys_clk(sys_clk), .rst_n(rst_n), .ctl_wr(ctl_wr),
        .ctl_base(ctl_base), .ctl_ctype(ctl_ctype), .lb_req(lb_req), .lb_wr(lb_wr),
        .lb_offset(lb_offset), .lb_wdata(lb_wdata), .lb_ack(lb_ack),
        .lb_refused(lb_refused), .lb_rdata(lb_rdata), .pci_req(pci_req),
        .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_wdata(pci_wdata),
        .pci_done(pci_done), .pci_rdata(pci_rdata), .ext_cfg_wr(ext_cfg_wr),
        .ext_master_en(ext_master_en), .ext_host_hold(ext_host_hold),
        .ee_data(ee_data), .ee_clk(ee_clk), .ee_cs_n(ee_cs_n),
        .cfg_loaded(cfg_loaded), .master_en(master_en), .vendor_id(vendor_id),
        .device_id(device_id), .class_code(class_code), .lbus_cfg(lbus_cfg),
        .host_reset_out(host_reset_out), .host_reset_out_n(host_reset_out_n));

    lpdm_far_model #(.IMAGE(IMG)) far (.sys_clk(sys_clk), .rst_n(rst_n),
        .ee_clk(ee_clk), .ee_cs_n(ee_cs_n), .ee_data(ee_data), .pci_req(pci_req),
        .pci_addr(pci_addr), .lat(lat), .pci_done(pci_done), .pci_rdata(pci_rdata));

    // ------------------------------------------------------------
    // access tasks, all entered at a falling edge
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic set_window(input logic [31:0] b, input logic [2:0] ct);
        ctl_wr = 1'b1;
        ctl_base = b;
        ctl_ctype = ct;
        @(negedge sys_clk);
        ctl_wr = 1'b0;
    endtask

    task automatic acc(input logic w, input logic [15:0] off, input logic [31:0] wd,
                       input logic [3:0] ecmd, input logic eref, input logic [31:0] ea);
        int   k;
        logic seen;
        seen = 1'b0;
        lb_req = 1'b1;
        lb_wr = w;
        lb_offset = off;
        lb_wdata = wd;
        @(negedge sys_clk);
        lb_req = 1'b0;
        for (k = 0; k < 60 && lb_ack !== 1'b1; k++)
        begin
            if (pci_req === 1'b1 && !seen)
            begin
                seen = 1'b1;
                check(pci_cmd, ecmd);
                check(pci_addr, ea);
                if (w)
                    check(pci_wdata, wd);
            end
            @(negedge sys_clk);
        end
        check(lb_ack, 1'b1);
        check(lb_refused, eref);
        check(seen, !eref);
        check(lb_rdata, eref ? `LPDM_RD_REFUSED : (w ? 32'h0 : ~ea));
    endtask

    task automatic ext_write(input logic en, input logic hold, input logic ee, input logic eh);
        ext_cfg_wr = 1'b1;
        ext_master_en = en;
        ext_host_hold = hold;
        @(negedge sys_clk);
        ext_cfg_wr = 1'b0;
        @(negedge sys_clk);
        check(master_en, ee);
        check(host_reset_out, eh);
        check(host_reset_out_n, !eh);
    endtask

    task automatic results();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // image load alone takes about 79000 cycles
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        results();
    end

    initial
    begin
        {ctl_wr, lb_req, lb_wr, ext_cfg_wr, ext_master_en, ext_host_hold} = 6'h00;
        ctl_base = 32'h0;
        ctl_ctype = 3'h0;
        lb_offset = 16'h0;
        lb_wdata = 32'h0;
        lat = 4'h0;
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(master_en, `LPDM_RST_MASTER_EN);
        check(host_reset_out, `LPDM_RST_HOST_RST);
        check(host_reset_out_n, !`LPDM_RST_HOST_RST);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(ee_cs_n, 1'b0);
        set_window(32'h0000_1000, 3'h2);
        acc(1'b0, 16'h0010, 32'h0, 4'h0, 1'b1, 32'h0);
        ext_write(1'b1, 1'b0, 1'b0, 1'b1);
        for (n = 0; n < 85000 && cfg_loaded !== 1'b1; n++)
            @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        check(cfg_loaded, 1'b1);
        check(master_en, 1'b1);
        check({vendor_id, device_id}, {VEND, DEV});
        check(class_code, CLS);
        check(lbus_cfg, LBUS);
        check({host_reset_out, host_reset_out_n}, 2'h1);
        check({ee_cs_n, ee_clk}, 2'h2);
        for (i = 0; i < 5; i++)
        begin
            base = {i[3:0], 28'hFFFFFF0};
            lat = i[0] ? 4'h5 : 4'h0;
            set_window(base, i[2:0]);
            acc(1'b0, 16'h0F0C, 32'h0, rd_cmd[i], 1'b0, base + 32'h0F0C);
            acc(1'b1, 16'hFFFC, ~base, wr_cmd[i], 1'b0, base + 32'hFFFC);
        end
        set_window(32'h8000_0000, 3'h7);
        acc(1'b0, 16'h0004, 32'h0, `LPDM_CMD_MEM_RD, 1'b0, 32'h8000_0004);
        ext_write(1'b0, 1'b1, 1'b0, 1'b1);
        set_window(32'h0001_0000, 3'h0);
        acc(1'b0, 16'h0000, 32'h0, 4'h0, 1'b1, 32'h0);
        ext_write(1'b1, 1'b0, 1'b1, 1'b0);
        acc(1'b1, 16'h0004, 32'h5A, `LPDM_CMD_CFG_WR, 1'b0, 32'h0001_0004);
        results();
    end
endmodule
`default_nettype wire

// ==== verif/lpdm_far_model.sv ====
// far side model: serial image memory and pci target
`timescale 1ns/100ps
`default_nettype none
module lpdm_far_model
#(
    parameter logic [78:0] IMAGE = 79'h0
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ee_clk,
    input  wire logic        ee_cs_n,
    output logic             ee_data,
    input  wire logic        pci_req,
    input  wire logic [31:0] pci_addr,
    input  wire logic [3:0]  lat,
    output logic             pci_done,
    output logic [31:0]      pci_rdata
);
    logic [6:0] idx;
    int         cnt;
    logic       served;

    // ------------------------------------------------------------
    // serial memory, msb first
    // ------------------------------------------------------------
    initial ee_data = 1'b0;
    initial pci_done = 1'b0;
    always @(negedge ee_cs_n)
    begin
        idx = 7'h4E;
        ee_data = IMAGE[78];
    end
    // bit moves while the clock is low, far from the sampling edge
    always @(negedge ee_clk)
    begin
        if (!ee_cs_n && idx != 7'h00)
        begin
            idx = idx - 7'h01;
            ee_data = IMAGE[idx];
        end
    end
    // no keeper on a deselected pin: never leave the last bit showing
    always @(posedge ee_cs_n)
        ee_data = ~ee_data;

    // ------------------------------------------------------------
    // pci target, answers after lat cycles
    // ------------------------------------------------------------
    always @(negedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pci_done <= 1'b0;
            cnt = 0;
            served = 1'b0;
        end
        else
        begin
            pci_done <= 1'b0;
            if (pci_req !== 1'b1)
            begin
                cnt = 0;
                served = 1'b0;
            end
            else if (!served)
            begin
                if (cnt >= lat)
                begin
                    pci_done <= 1'b1;
                    served = 1'b1;
                end
                cnt++;
            end
        end
    end
    // data only valid with done: inverted address with done, plain address otherwise
    assign pci_rdata = pci_done ? ~pci_addr : pci_addr;
endmodule
`default_nettype wire
